// >>> src/index_seq_pkg.sv
// Constants, register map and carrier types for the index sequence I/O block.
// Assumes an APB master on pclk, 32-bit data, one register per aligned word.
// Function
// - Input selector 0 off, 1-A channel, B on
// - Selector B forces logical input asserted
// - Outputs routed by digits, reserved digits ignored
// - Map changes only while disabled, configure then end
// - Start edge begins index, asserts in-motion
// - Start resumes wait-for-start and overrides pause
// - Start ignored while homing or in motion
// - Select inputs sampled at start edge
// - Select changes ignored while in motion
// - Index outputs show running index in motion
// - Stopped: index outputs hold last completed index
// - Pause edge retains index, decelerates motor
// - In-motion stays asserted while paused
// - Start while paused resumes retained index
// - Stop while paused cancels, ready again
// - Stop in motion decelerates and cancels
// - Stop edge cancels and clears in-motion
// - Wait-for-start: in-motion clears at each target
package index_seq_pkg;

  localparam int NUM_IN_CH  = 10;
  localparam int NUM_OUT_CH = 3;
  localparam int SEL_W      = 4;
  localparam int IDX_W      = 6;

  localparam logic [3:0] SEL_OFF = 4'h0;
  localparam logic [3:0] SEL_ON  = 4'hB;

  // Logical input function slots, digit order of the three input map words
  localparam int FN_ENABLE = 0;
  localparam int FN_FWD_OT = 1;
  localparam int FN_REV_OT = 2;
  localparam int FN_START  = 3;
  localparam int FN_PAUSE  = 4;
  localparam int FN_STOP   = 5;
  localparam int FN_SEL0   = 6;
  localparam int NUM_FN    = 12;

  // Register byte offsets
  localparam logic [7:0] ADDR_IN_A    = 8'h00;
  localparam logic [7:0] ADDR_IN_B    = 8'h04;
  localparam logic [7:0] ADDR_IN_C    = 8'h08;
  localparam logic [7:0] ADDR_OUT_A   = 8'h0C;
  localparam logic [7:0] ADDR_OUT_B   = 8'h10;
  localparam logic [7:0] ADDR_OUT_C   = 8'h14;
  localparam logic [7:0] ADDR_OUT_D   = 8'h18;
  localparam logic [7:0] ADDR_CTRL    = 8'h1C;
  localparam logic [7:0] ADDR_STATUS  = 8'h20;

  // Control bits
  localparam int CTRL_CONFIG = 0;
  localparam int CTRL_END    = 1;

  // Reset values of the map words
  localparam logic [15:0] RST_IN_A  = 16'h4BB1;
  localparam logic [15:0] RST_IN_B  = 16'h0765;
  localparam logic [15:0] RST_IN_C  = 16'h0000;
  localparam logic [15:0] RST_OUT_A = 16'h0321;
  localparam logic [15:0] RST_OUT_X = 16'h0000;
  localparam logic [15:0] MASK_RSVD = 16'h00FF;

  typedef enum logic [1:0] {
    ACT_STOP,
    ACT_NEXT,
    ACT_WAIT
  } action_t;

  typedef struct packed {
    logic start;
    logic pause;
    logic stop;
  } seq_edges_t;

endpackage : index_seq_pkg

// >>> src/input_router.sv
// Synchroniser, allocation map and edge detector for the physical inputs.
// Assumes map words are stable while the drive is enabled.
module input_router #(
  parameter int NCH = index_seq_pkg::NUM_IN_CH,
  parameter int NFN = index_seq_pkg::NUM_FN
) (
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // Physical inputs and allocation
  input  wire logic [NCH-1:0]          phys_in,
  input  wire logic [NFN*4-1:0]        map_sel,
  // Logical functions
  output logic      [NFN-1:0]          func_level,
  output logic      [NFN-1:0]          func_rise
);

  logic [NCH-1:0] sync_a;
  logic [NCH-1:0] sync_b;
  wire logic [NFN-1:0] level_now;
  logic           primed;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= phys_in;
      sync_b <= sync_a;
    end
  end

  function automatic logic route(input logic [3:0] sel, input logic [NCH-1:0] ch);
    logic r;
    r = 1'b0;
    if (sel == index_seq_pkg::SEL_ON) begin
      r = 1'b1;
    end else if (sel != index_seq_pkg::SEL_OFF && sel <= 4'(NCH)) begin
      r = ch[sel - 4'h1];
    end
    return r;
  endfunction : route

  genvar g;
  generate
    for (g = 0; g < NFN; g++) begin : g_fn
      assign level_now[g] = route(map_sel[g*4 +: 4], sync_b);
    end
  endgenerate

  // First sample after reset only primes, so a selector held at B gives no false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primed     <= 1'b0;
      func_level <= '0;
      func_rise  <= '0;
    end else begin
      primed     <= 1'b1;
      func_level <= level_now;
      func_rise  <= primed ? (level_now & ~func_level) : '0;
    end
  end

endmodule : input_router

// >>> src/index_seq_io.sv
// Index sequence I/O control: APB map registers, input routing, index sequencer, output routing.
// Assumes motion timing comes from the motion core via move_done and decel_done.
module index_seq_io #(
  parameter int NCH  = index_seq_pkg::NUM_IN_CH,
  parameter int NOUT = index_seq_pkg::NUM_OUT_CH
) (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Physical I/O
  input  wire logic [NCH-1:0]  phys_in,
  output logic      [NOUT-1:0] phys_out,
  // Motion core
  input  wire logic        homing_busy,
  input  wire logic        move_done,
  input  wire logic        decel_done,
  input  wire logic [1:0]  done_action,
  output logic             move_go,
  output logic             move_decel,
  output logic [5:0]       move_index,
  // Sequence outputs
  output logic             in_motion_flag,
  output logic [5:0]       index_number_outputs,
  output logic             drive_enable,
  output logic             forward_overtravel,
  output logic             reverse_overtravel
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MOVE,
    ST_PAUSING,
    ST_PAUSED,
    ST_STOPPING
  } seq_state_t;

  seq_state_t state;
  logic [15:0] in_a, in_b, in_c;
  logic [15:0] out_a, out_b, out_c, out_d;
  logic [15:0] act_a, act_b, act_c, act_oa;
  logic        configuring;
  logic [index_seq_pkg::NUM_FN-1:0] f_lvl, f_rise;
  wire index_seq_pkg::seq_edges_t ev;
  logic        wr, rd;
  logic [5:0]  sel_code;
  logic [5:0]  last_done;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  function automatic logic mapped(input logic [7:0] a);
    return a <= index_seq_pkg::ADDR_STATUS && a[1:0] == 2'b00;
  endfunction : mapped

  // Map registers: writable only while the drive is disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_a  <= index_seq_pkg::RST_IN_A;
      in_b  <= index_seq_pkg::RST_IN_B;
      in_c  <= index_seq_pkg::RST_IN_C;
      out_a <= index_seq_pkg::RST_OUT_A;
      out_b <= index_seq_pkg::RST_OUT_X;
      out_c <= index_seq_pkg::RST_OUT_X;
      out_d <= index_seq_pkg::RST_OUT_X;
      configuring <= 1'b0;
    end else if (wr && !drive_enable) begin
      case (paddr)
        index_seq_pkg::ADDR_IN_A:  in_a  <= pwdata[15:0];
        index_seq_pkg::ADDR_IN_B:  in_b  <= pwdata[15:0];
        index_seq_pkg::ADDR_IN_C:  in_c  <= pwdata[15:0];
        index_seq_pkg::ADDR_OUT_A: out_a <= pwdata[15:0];
        index_seq_pkg::ADDR_OUT_B: out_b <= pwdata[15:0];
        index_seq_pkg::ADDR_OUT_C: out_c <= pwdata[15:0] & index_seq_pkg::MASK_RSVD;
        index_seq_pkg::ADDR_OUT_D: out_d <= pwdata[15:0] & index_seq_pkg::MASK_RSVD;
        index_seq_pkg::ADDR_CTRL: begin
          if (pwdata[index_seq_pkg::CTRL_CONFIG]) begin
            configuring <= 1'b1;
          end
          if (pwdata[index_seq_pkg::CTRL_END]) begin
            configuring <= 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // Active map copies load at the end step, so edits take effect together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_a  <= index_seq_pkg::RST_IN_A;
      act_b  <= index_seq_pkg::RST_IN_B;
      act_c  <= index_seq_pkg::RST_IN_C;
      act_oa <= index_seq_pkg::RST_OUT_A;
    end else if (wr && !drive_enable && configuring && paddr == index_seq_pkg::ADDR_CTRL
                 && pwdata[index_seq_pkg::CTRL_END]) begin
      act_a  <= in_a;
      act_b  <= in_b;
      act_c  <= in_c;
      act_oa <= out_a;
    end
  end

  // APB answers in the access cycle with no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped(paddr);
      prdata  <= '0;
      if (rd) begin
        case (paddr)
          index_seq_pkg::ADDR_IN_A:   prdata <= {16'h0000, in_a};
          index_seq_pkg::ADDR_IN_B:   prdata <= {16'h0000, in_b};
          index_seq_pkg::ADDR_IN_C:   prdata <= {16'h0000, in_c};
          index_seq_pkg::ADDR_OUT_A:  prdata <= {16'h0000, out_a};
          index_seq_pkg::ADDR_OUT_B:  prdata <= {16'h0000, out_b};
          index_seq_pkg::ADDR_OUT_C:  prdata <= {16'h0000, out_c};
          index_seq_pkg::ADDR_OUT_D:  prdata <= {16'h0000, out_d};
          index_seq_pkg::ADDR_CTRL:   prdata <= {31'h00000000, configuring};
          index_seq_pkg::ADDR_STATUS: prdata <= {16'h0000, 5'h00, drive_enable, 1'b0,
                                                 index_number_outputs, 2'b00, in_motion_flag};
          default:                    prdata <= '0;
        endcase
      end
    end
  end

  input_router #(
    .NCH (NCH),
    .NFN (index_seq_pkg::NUM_FN)
  ) u_router (
    .pclk       (pclk),
    .presetn    (presetn),
    .phys_in    (phys_in),
    .map_sel    ({act_c, act_b, act_a}),
    .func_level (f_lvl),
    .func_rise  (f_rise)
  );

  assign ev.start = f_rise[index_seq_pkg::FN_START];
  assign ev.pause = f_rise[index_seq_pkg::FN_PAUSE];
  assign ev.stop  = f_rise[index_seq_pkg::FN_STOP];
  assign sel_code = f_lvl[index_seq_pkg::FN_SEL0 +: 6];

  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ST_IDLE;
      move_index <= '0;
      move_go    <= 1'b0;
      move_decel <= 1'b0;
    end else begin
      move_go    <= 1'b0;
      move_decel <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (ev.start && !homing_busy) begin
            move_index <= sel_code;
            move_go    <= 1'b1;
            state      <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          if (ev.stop) begin
            move_decel <= 1'b1;
            state      <= ST_STOPPING;
          end else if (ev.pause) begin
            move_decel <= 1'b1;
            state      <= ST_PAUSING;
          end else if (move_done) begin
            if (done_action == 2'(index_seq_pkg::ACT_NEXT)) begin
              move_index <= move_index + 6'h01;
              move_go    <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_PAUSING: begin
          if (ev.stop) begin
            state <= ST_STOPPING;
          end else if (ev.start) begin
            move_go <= 1'b1;
            state   <= ST_MOVE;
          end else if (decel_done) begin
            state <= ST_PAUSED;
          end
        end
        ST_PAUSED: begin
          if (ev.stop) begin
            state <= ST_IDLE;
          end else if (ev.start) begin
            move_go <= 1'b1;
            state   <= ST_MOVE;
          end
        end
        ST_STOPPING: begin
          if (decel_done) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Flag follows sequencer; cleared at once on stop, kept through pause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_motion_flag <= 1'b0;
    end else begin
      in_motion_flag <= (state == ST_IDLE) ? (ev.start && !homing_busy)
                      : (state == ST_STOPPING) ? 1'b0
                      : (state == ST_MOVE) ? !ev.stop && !(move_done && done_action != 2'(index_seq_pkg::ACT_NEXT))
                      : !ev.stop;
    end
  end

  // Last index that reached its target; a cancelled index never becomes the shown number
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_done <= '0;
    end else if (state == ST_MOVE && move_done && !ev.stop && !ev.pause) begin
      last_done <= move_index;
    end
  end

  // Running index while moving, last completed index otherwise; select changes in motion are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_number_outputs <= '0;
    end else if (state == ST_MOVE || state == ST_PAUSING || state == ST_PAUSED) begin
      index_number_outputs <= move_index;
    end else begin
      index_number_outputs <= last_done;
    end
  end

  // Output routing, one channel per digit value; a digit of zero drives no channel
  function automatic logic digit_hit(input logic [3:0] digit, input int ch);
    return digit == 4'(ch + 1);
  endfunction : digit_hit

  wire logic [NOUT-1:0] next_phys_out;
  genvar o;
  generate
    for (o = 0; o < NOUT; o++) begin : g_out
      assign next_phys_out[o] = (digit_hit(act_oa[3:0], o) && in_motion_flag)
                             || (digit_hit(act_oa[7:4], o) && index_number_outputs[0])
                             || (digit_hit(act_oa[11:8], o) && !drive_enable);
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phys_out <= '0;
    end else begin
      phys_out <= next_phys_out;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_enable       <= 1'b0;
      forward_overtravel <= 1'b0;
      reverse_overtravel <= 1'b0;
    end else begin
      drive_enable       <= f_lvl[index_seq_pkg::FN_ENABLE];
      forward_overtravel <= f_lvl[index_seq_pkg::FN_FWD_OT];
      reverse_overtravel <= f_lvl[index_seq_pkg::FN_REV_OT];
    end
  end

  a_start_motion: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_IDLE && ev.start && !homing_busy) |=> (move_go && in_motion_flag))
    else $error("start edge did not begin motion");
  a_homing_block: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_IDLE && homing_busy) |=> !move_go)
    else $error("start accepted while homing");
  a_select_latch: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_IDLE && ev.start && !homing_busy) |=> move_index == $past(sel_code))
    else $error("index select not latched");
  a_select_ignore: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_MOVE && !move_done) |=> $stable(move_index))
    else $error("index changed in motion");
  a_pause_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_PAUSED && !ev.stop) |=> in_motion_flag)
    else $error("in-motion dropped while paused");
  a_stop_cancel: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_MOVE && ev.stop) |=> (!in_motion_flag && move_decel))
    else $error("stop did not cancel");
  a_paused_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_PAUSED && ev.stop) |=> state == ST_IDLE)
    else $error("stop while paused did not cancel");
  a_pause_resume: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_PAUSED && ev.start && !ev.stop) |=> (move_go && state == ST_MOVE))
    else $error("start did not resume");
  a_pausing_resume: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_PAUSING && ev.start && !ev.stop) |=> (move_go && state == ST_MOVE))
    else $error("start did not override pause");
  a_start_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_MOVE && ev.start && !move_done) |=> !move_go)
    else $error("start accepted in motion");
  a_pause_decel: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_MOVE && ev.pause && !ev.stop && !move_done) |=> (move_decel && state == ST_PAUSING && in_motion_flag))
    else $error("pause did not decelerate");
  a_pausing_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_PAUSING && !ev.stop) |=> in_motion_flag)
    else $error("in-motion dropped while pausing");
  a_resume_index: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_PAUSED && ev.start && !ev.stop) |=> $stable(move_index))
    else $error("resume lost the retained index");
  a_stop_decel: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_MOVE && ev.stop) |=> state == ST_STOPPING)
    else $error("stop did not decelerate");
  a_stopping_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_STOPPING) |=> !in_motion_flag)
    else $error("in-motion set while stopping");
  a_target_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_MOVE && !ev.stop && !ev.pause && move_done && done_action == 2'(index_seq_pkg::ACT_WAIT))
    |=> (!in_motion_flag && state == ST_IDLE))
    else $error("in-motion kept at target");
  a_index_running: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_MOVE) |=> index_number_outputs == $past(move_index))
    else $error("running index not shown");
  a_index_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_IDLE) |=> index_number_outputs == $past(last_done))
    else $error("completed index not held");
  a_map_locked: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && drive_enable) |=> ($stable(in_a) && $stable(act_a)))
    else $error("map changed while enabled");

endmodule : index_seq_io

// >>> sim/motion_core_model.sv
// Motion core model: answers move starts and deceleration requests.
// Assumes single-cycle move_go and move_decel pulses on pclk.
module motion_core_model #(
  parameter int MOVE_CYC = 12,
  parameter int DEC_CYC  = 4
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Requests
  input  wire logic move_go,
  input  wire logic move_decel,
  input  wire logic auto_done,
  // Answers
  output logic      move_done,
  output logic      decel_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int   mv_cnt;
  int   dc_cnt;
  logic moving;
  // Moves finish only while the bench allows it, so a move can be held open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      moving     <= 1'b0;
      mv_cnt     <= 0;
      dc_cnt     <= 0;
      move_done  <= 1'b0;
      decel_done <= 1'b0;
    end else begin
      move_done  <= 1'b0;
      decel_done <= 1'b0;
      if (move_go) begin
        moving <= 1'b1;
        mv_cnt <= 0;
      end else if (move_decel) begin
        moving <= 1'b0;
      end else if (moving && auto_done) begin
        mv_cnt <= mv_cnt + 1;
        if (mv_cnt == MOVE_CYC) begin
          moving    <= 1'b0;
          move_done <= 1'b1;
        end
      end
      if (move_decel) dc_cnt <= DEC_CYC;
      else if (dc_cnt > 0) dc_cnt <= dc_cnt - 1;
      if (dc_cnt == 1) decel_done <= 1'b1;
    end
  end
endmodule : motion_core_model

// >>> sim/index_seq_io_test.sv
// Testbench for index_seq_io: APB map access and index sequencing.
// Assumes the motion core model answers moves and decelerations.
module index_seq_io_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [9:0]  phys_in = 10'h000;
  logic [2:0]  phys_out;
  logic        homing_busy = 1'b0;
  logic        move_done;
  logic        decel_done;
  logic        move_go;
  logic        move_decel;
  logic [1:0]  done_action = 2'h2;
  logic [5:0]  move_index;
  logic [5:0]  index_number_outputs;
  logic        in_motion_flag;
  logic        drive_enable;
  logic        forward_overtravel;
  logic        reverse_overtravel;
  logic        auto_done = 1'b0;
  logic [31:0] rd;
  logic        er;
  int          err_count = 0;
  int          checked = 0;
  int          go_cnt = 0;
  int          g0;

  index_seq_io u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .phys_in, .phys_out, .homing_busy, .move_done, .decel_done, .done_action, .move_go,
    .move_decel, .move_index, .in_motion_flag, .index_number_outputs, .drive_enable,
    .forward_overtravel, .reverse_overtravel);
  motion_core_model u_core (.pclk, .presetn, .move_go, .move_decel, .auto_done, .move_done,
    .decel_done);

  always #20 pclk = ~pclk;
  always @(posedge pclk) if (move_go === 1'b1) go_cnt++;

  task automatic end_sim;
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic sig(input int k);
    case (k)
      0: return move_go;
      1: return move_decel;
      2: return decel_done;
      3: return ~in_motion_flag;
      default: return pready;
    endcase
  endfunction : sig

  // Bounded wait; a hang ends the run as a failure
  task automatic wait_hi(input int k);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sig(k) !== 1'b1 && n < 200);
    if (n >= 200) begin
      err_count++;
      $display("[FAIL] %0t wait timed out", $time);
      end_sim();
    end
  endtask : wait_hi

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    wait_hi(4);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic setin(input int ch, input logic v);
    @(posedge pclk);
    phys_in[ch-1] <= v;
    repeat (6) @(posedge pclk);
  endtask : setin

  task automatic rise(input int ch);
    setin(ch, 1'b0);
    phys_in[ch-1] <= 1'b1;
  endtask : rise

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Levels pass the synchroniser, the function register and the output register first
    repeat (4) @(posedge pclk);
    chk({reverse_overtravel, forward_overtravel, drive_enable, phys_out}, 6'h34);
    apb(1'b0, index_seq_pkg::ADDR_IN_A, 32'h0);
    chk(rd, 32'h0000_4BB1);
    apb(1'b0, index_seq_pkg::ADDR_OUT_A, 32'h0);
    chk(rd, 32'h0000_0321);
    apb(1'b0, 8'h24, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, index_seq_pkg::ADDR_OUT_C, 32'h0000_FF00);
    apb(1'b0, index_seq_pkg::ADDR_OUT_C, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b1, index_seq_pkg::ADDR_OUT_B, 32'h0);
    apb(1'b1, index_seq_pkg::ADDR_IN_A, 32'h0000_4301);
    repeat (4) @(posedge pclk);
    chk(forward_overtravel, 1'b1);
    apb(1'b1, index_seq_pkg::ADDR_CTRL, 32'h1);
    apb(1'b1, index_seq_pkg::ADDR_CTRL, 32'h2);
    setin(3, 1'b1);
    chk({reverse_overtravel, forward_overtravel}, 2'b10);
    setin(3, 1'b0);
    chk(reverse_overtravel, 1'b0);
    setin(1, 1'b1);
    chk(drive_enable, 1'b1);
    apb(1'b1, index_seq_pkg::ADDR_IN_A, 32'h0);
    apb(1'b0, index_seq_pkg::ADDR_IN_A, 32'h0);
    chk(rd, 32'h0000_4301);
    // Select is held far longer around each start than the sampler needs
    setin(7, 1'b1);
    rise(4);
    wait_hi(0);
    chk(move_index, 6'h01);
    repeat (2) @(posedge pclk);
    chk({in_motion_flag, phys_out}, 4'hB);
    chk(index_number_outputs, 6'h01);
    apb(1'b0, index_seq_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_0409);
    g0 = go_cnt;
    setin(7, 1'b0);
    rise(4);
    repeat (10) @(posedge pclk);
    chk(go_cnt, g0);
    chk(index_number_outputs, 6'h01);
    auto_done <= 1'b1;
    wait_hi(3);
    auto_done <= 1'b0;
    chk(index_number_outputs, 6'h01);
    rise(4);
    wait_hi(0);
    chk(move_index, 6'h00);
    rise(5);
    wait_hi(1);
    wait_hi(2);
    repeat (3) @(posedge pclk);
    chk(in_motion_flag, 1'b1);
    setin(7, 1'b1);
    rise(4);
    wait_hi(0);
    chk(move_index, 6'h00);
    rise(5);
    wait_hi(2);
    rise(6);
    repeat (8) @(posedge pclk);
    chk(in_motion_flag, 1'b0);
    chk(index_number_outputs, 6'h01);
    rise(4);
    wait_hi(0);
    chk(move_index, 6'h01);
    rise(6);
    wait_hi(1);
    repeat (2) @(posedge pclk);
    chk(in_motion_flag, 1'b0);
    wait_hi(2);
    homing_busy <= 1'b1;
    g0 = go_cnt;
    rise(4);
    repeat (10) @(posedge pclk);
    chk(go_cnt, g0);
    end_sim();
  end
endmodule : index_seq_io_test
